// [cfgio_pins_model.sv]
// Pin-side model: resolves each pin from port drive, outside drive and pull-up
`timescale 1ns/1ps
`default_nettype none
module cfgio_pins_model
    import cfgio_pkg::*;
(
    input wire logic clk,
    input wire cfgio_byte_t drv_val,
    input wire cfgio_byte_t drv_en,
    input wire cfgio_byte_t pull_en,
    input wire cfgio_byte_t ext_val,
    input wire cfgio_byte_t ext_en,
    output cfgio_byte_t level
);
    // An undriven pin wanders, so no check can lean on a stale level
    cfgio_byte_t float_q = 8'h00;
    always @(posedge clk) float_q <= ~level;
    always_comb begin
        for (int g = 0; g < 8; g++) begin
            // Port drive wins over the outside; a released high falls through
            level[g] = drv_en[g] ? drv_val[g] :
                ext_en[g] ? ext_val[g] : (pull_en[g] | float_q[g]);
        end
    end
endmodule
`default_nettype wire

// [cfgio_pkg.sv]
// Types shared by the I/O port design
package cfgio_pkg;
    typedef logic [7:0] cfgio_byte_t;
    typedef enum logic [1:0] {
        CFGIO_TRIG_FALL,
        CFGIO_TRIG_RISE,
        CFGIO_TRIG_LOW,
        CFGIO_TRIG_RSVD
    } cfgio_trig_t;
endpackage

// [cfgio_port.sv]
// Eight-pin configurable I/O port with external interrupt request
// What this block does
// - Each pin uses its own bit of direction, option and data registers.
// - Reset clears all registers: input, pull-up, no interrupt.
// - Direction 0 makes an input; data reads return the live pin.
// - Dir 0, option 0, data 0: input with pull-up, no interrupt.
// - Dir 0, option 0, data 1: input without pull-up, no interrupt.
// - Dir 0, option 1, data 0: pull-up input feeding the port interrupt.
// - Dir 0, option 1, data 1: analog input to the converter where supported.
// - Dir 1, option 0: open-drain output, data picks the level.
// - Dir 1, option 1: push-pull output, data picks the level.
// - In output mode data writes load the latch, reads return it.
// - Open-drain drives low for 0 and floats for 1.
// - Push-pull drives low for 0 and high for 1.
// - Requests need an interrupt-enabled pin and the global enable set.
// - Trigger per port: falling edge, rising edge or low level.
// - Wait and stop keep configuration; enabled interrupts wake the device.
// - No automatic alternate function; only the three bits select it.
// - One shared request per port toward its own vector.
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "cfgio_regs.svh"
module cfgio_port
    import cfgio_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`CFGIO_AW-1:0] addr,
    input wire cfgio_byte_t wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output cfgio_byte_t rd_data_q,
    input wire logic irq_ack,
    input wire logic low_power,
    input wire cfgio_byte_t pin_in,
    output cfgio_byte_t pin_out_q,
    output cfgio_byte_t pin_oe_q,
    output cfgio_byte_t pullup_en_q,
    output cfgio_byte_t analog_sel_q,
    output logic irq_q,
    output logic wake_q
);
    cfgio_byte_t pin_data_latch_q;
    cfgio_byte_t dir_q;
    cfgio_byte_t opt_q;
    logic global_interrupt_enable_q;
    cfgio_trig_t trig_q;
    cfgio_byte_t pin_s;
    cfgio_byte_t pin_prev_q;
    cfgio_byte_t irq_src;
    cfgio_byte_t read_mux;
    logic edge_hit;
    logic level_hit;
    logic pend_q;
    logic req_d;
    // Only the low pins reach the converter; the rest stay digital in that mode
    localparam cfgio_byte_t analog_ok = `CFGIO_ANALOG_MASK;

    // Per-pin decode of the three configuration bits
    function automatic logic [3:0] pin_mode(input logic d, input logic o, input logic v);
        // {drive_en, drive_high, pullup, analog}
        pin_mode[3] = d & (o | ~v);
        pin_mode[2] = d & o & v;
        pin_mode[1] = ~d & ~v;
        pin_mode[0] = ~d & o & v;
    endfunction

    function automatic logic is_irq_src(input logic d, input logic o, input logic v);
        is_irq_src = ~d & o & ~v;
    endfunction

    cfgio_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(pin_in),
        .sync_out(pin_s)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_data_latch_q <= `CFGIO_RST_BYTE;
        end else if (wr_en && addr == `CFGIO_OFF_DATA) begin
            pin_data_latch_q <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dir_q <= `CFGIO_RST_BYTE;
        end else if (wr_en && addr == `CFGIO_OFF_DIR) begin
            dir_q <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            opt_q <= `CFGIO_RST_BYTE;
        end else if (wr_en && addr == `CFGIO_OFF_OPT) begin
            opt_q <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            global_interrupt_enable_q <= `CFGIO_RST_BIT;
            trig_q <= CFGIO_TRIG_FALL;
        end else if (wr_en && addr == `CFGIO_OFF_IOPT) begin
            global_interrupt_enable_q <= wr_data[`CFGIO_GEN_BIT];
            trig_q <= cfgio_trig_t'(wr_data[`CFGIO_TRIG_MSB:`CFGIO_TRIG_LSB]);
        end
    end

    // Low-power entry freezes nothing here: configuration only moves on bus writes
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_pin
            logic [3:0] m;
            assign m = pin_mode(dir_q[g], opt_q[g], pin_data_latch_q[g]);
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    pin_oe_q[g] <= 1'b0;
                    pin_out_q[g] <= 1'b0;
                    pullup_en_q[g] <= 1'b1;
                    analog_sel_q[g] <= 1'b0;
                end else begin
                    pin_oe_q[g] <= m[3];
                    pin_out_q[g] <= m[2];
                    pullup_en_q[g] <= m[1];
                    // Pins without an analog path stay digital
                    analog_sel_q[g] <= m[0] & analog_ok[g];
                end
            end
            assign irq_src[g] = is_irq_src(dir_q[g], opt_q[g], pin_data_latch_q[g]);
            // Input pins read live level, outputs read the latch
            assign read_mux[g] = dir_q[g] ? pin_data_latch_q[g] : pin_s[g];
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_prev_q <= `CFGIO_RST_BYTE;
        end else begin
            pin_prev_q <= pin_s;
        end
    end

    always_comb begin
        edge_hit = 1'b0;
        level_hit = 1'b0;
        case (trig_q)
            CFGIO_TRIG_FALL: edge_hit = |(irq_src & pin_prev_q & ~pin_s);
            CFGIO_TRIG_RISE: edge_hit = |(irq_src & ~pin_prev_q & pin_s);
            CFGIO_TRIG_LOW: level_hit = |(irq_src & ~pin_s);
            default: edge_hit = 1'b0;
        endcase
    end

    // An edge arriving with the acknowledge is kept
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pend_q <= `CFGIO_RST_BIT;
        end else if (edge_hit) begin
            pend_q <= 1'b1;
        end else if (irq_ack || trig_q == CFGIO_TRIG_LOW) begin
            pend_q <= 1'b0;
        end
    end

    assign req_d = global_interrupt_enable_q & (pend_q | level_hit);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            irq_q <= req_d;
            wake_q <= req_d & low_power;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data_q <= `CFGIO_RST_BYTE;
        end else if (rd_en) begin
            case (addr)
                `CFGIO_OFF_DATA: rd_data_q <= read_mux;
                `CFGIO_OFF_DIR: rd_data_q <= dir_q;
                `CFGIO_OFF_OPT: rd_data_q <= opt_q;
                `CFGIO_OFF_IOPT: rd_data_q <= {5'h00, trig_q, global_interrupt_enable_q};
                `CFGIO_OFF_STAT: rd_data_q <= {6'h00, irq_q, pend_q};
                default: rd_data_q <= `CFGIO_RST_BYTE;
            endcase
        end else begin
            rd_data_q <= `CFGIO_RST_BYTE;
        end
    end

    sequence data_write_s;
        wr_en && addr == `CFGIO_OFF_DATA;
    endsequence

    sequence fall_seen_s;
        global_interrupt_enable_q && trig_q == CFGIO_TRIG_FALL
            && |(irq_src & pin_prev_q & ~pin_s);
    endsequence

    sequence rise_seen_s;
        global_interrupt_enable_q && trig_q == CFGIO_TRIG_RISE
            && |(irq_src & ~pin_prev_q & pin_s);
    endsequence

    reset_clears_a: assert property (@(posedge clk)
        !rst_n |=> dir_q == 8'h00 && opt_q == 8'h00 && pin_data_latch_q == 8'h00)
        else $error("registers not cleared by reset");

    pull_up_a: assert property (@(posedge clk) disable iff (!rst_n)
        !dir_q[0] && !pin_data_latch_q[0] |=> pullup_en_q[0] && !pin_oe_q[0])
        else $error("input pin lacks pull-up");

    analog_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
        !dir_q[0] && opt_q[0] && pin_data_latch_q[0] |=> analog_sel_q[0] && !pullup_en_q[0])
        else $error("analog pin not routed");

    open_drain_a: assert property (@(posedge clk) disable iff (!rst_n)
        dir_q[0] && !opt_q[0] |=> pin_oe_q[0] == !$past(pin_data_latch_q[0]) && !pin_out_q[0])
        else $error("open-drain drive wrong");

    push_pull_a: assert property (@(posedge clk) disable iff (!rst_n)
        dir_q[0] && opt_q[0] |=> pin_oe_q[0] && pin_out_q[0] == $past(pin_data_latch_q[0]))
        else $error("push-pull drive wrong");

    input_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd_en && addr == `CFGIO_OFF_DATA && !dir_q[0] |=> rd_data_q[0] == $past(pin_s[0]))
        else $error("input read not live pin");

    latch_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        data_write_s ##1 (rd_en && addr == `CFGIO_OFF_DATA && dir_q[0] && !wr_en)
            |=> rd_data_q[0] == $past(wr_data[0], 2))
        else $error("output read not latch");

    gen_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        !global_interrupt_enable_q |=> !irq_q)
        else $error("request without global enable");

    fall_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
        fall_seen_s ##1 global_interrupt_enable_q |=> irq_q)
        else $error("falling edge missed");

    read_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        !rd_en |=> rd_data_q == 8'h00)
        else $error("read data outside read slot");

    reset_pins_a: assert property (@(posedge clk)
        !rst_n |=> pullup_en_q == 8'hff && pin_oe_q == 8'h00 && !irq_q)
        else $error("pins not safe after reset");

    input_no_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
        !dir_q[0] |=> !pin_oe_q[0])
        else $error("input pin driven");

    od_pullup_a: assert property (@(posedge clk) disable iff (!rst_n)
        dir_q[0] |=> !pullup_en_q[0] && !analog_sel_q[0])
        else $error("output pin keeps input options");

    analog_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> (analog_sel_q & ~analog_ok) == 8'h00)
        else $error("analog route on digital-only pin");

    dir_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && addr == `CFGIO_OFF_DIR |=> dir_q == $past(wr_data))
        else $error("direction write lost");

    opt_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && addr == `CFGIO_OFF_OPT |=> opt_q == $past(wr_data))
        else $error("option write lost");

    latch_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !(wr_en && addr == `CFGIO_OFF_DATA) |=> $stable(pin_data_latch_q))
        else $error("data latch moved without write");

    dir_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd_en && addr == `CFGIO_OFF_DIR |=> rd_data_q == $past(dir_q))
        else $error("direction read wrong");

    opt_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd_en && addr == `CFGIO_OFF_OPT |=> rd_data_q == $past(opt_q))
        else $error("option read wrong");

    stat_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd_en && addr == `CFGIO_OFF_STAT
            |=> rd_data_q == {6'h00, $past(irq_q), $past(pend_q)})
        else $error("status read wrong");

    unmapped_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd_en && addr > `CFGIO_OFF_STAT |=> rd_data_q == 8'h00)
        else $error("unmapped read not zero");

    rise_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
        rise_seen_s ##1 global_interrupt_enable_q |=> irq_q)
        else $error("rising edge missed");

    low_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
        global_interrupt_enable_q && trig_q == CFGIO_TRIG_LOW && |(irq_src & ~pin_s)
            |=> irq_q)
        else $error("low level missed");

    low_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        trig_q == CFGIO_TRIG_LOW && !pend_q && !(|(irq_src & ~pin_s)) |=> !irq_q)
        else $error("low level request without low pin");

    edge_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        edge_hit |=> pend_q)
        else $error("edge not recorded");

    ack_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        irq_ack && !edge_hit |=> !pend_q)
        else $error("acknowledge left request pending");

    rsvd_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        trig_q == CFGIO_TRIG_RSVD && !pend_q |=> !pend_q)
        else $error("edge recorded with trigger off");

    no_src_a: assert property (@(posedge clk) disable iff (!rst_n)
        irq_src == 8'h00 && !pend_q |=> !irq_q)
        else $error("request without source pin");

    wake_a: assert property (@(posedge clk) disable iff (!rst_n)
        low_power && req_d |=> wake_q)
        else $error("wake missed in low power");

    no_wake_a: assert property (@(posedge clk) disable iff (!rst_n)
        !low_power |=> !wake_q)
        else $error("wake outside low power");

    wake_gen_a: assert property (@(posedge clk) disable iff (!rst_n)
        !global_interrupt_enable_q |=> !wake_q)
        else $error("wake without global enable");

    keep_cfg_a: assert property (@(posedge clk) disable iff (!rst_n)
        low_power && !wr_en
            |=> $stable(dir_q) && $stable(opt_q) && $stable(pin_data_latch_q))
        else $error("configuration moved in low power");
endmodule
`default_nettype wire

// [cfgio_port_tb_top.sv]
// Self-checking bench for the configurable I/O port
`timescale 1ns/1ps
`default_nettype none
`include "cfgio_regs.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module cfgio_port_tb_top
    import cfgio_pkg::*;
();
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [`CFGIO_AW-1:0] addr = '0;
    logic wr_en = 1'b0, rd_en = 1'b0, irq_ack = 1'b0, low_power = 1'b0;
    logic irq_q, wake_q, rd_seen = 1'b0;
    cfgio_byte_t wr_data = 8'h00, ext_val = 8'h00, ext_en = 8'h00;
    cfgio_byte_t rd_data_q, pin_in, pin_out_q, pin_oe_q, pullup_en_q, analog_sel_q;
    cfgio_byte_t dir, opt, dat, an, e_v;
    cfgio_byte_t exp_q[$];
    int n_fail = 0;
    int checked = 0;
    always #10 clk = ~clk;
    cfgio_port dut_u (.clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q), .irq_ack(irq_ack),
        .low_power(low_power), .pin_in(pin_in), .pin_out_q(pin_out_q),
        .pin_oe_q(pin_oe_q), .pullup_en_q(pullup_en_q), .analog_sel_q(analog_sel_q),
        .irq_q(irq_q), .wake_q(wake_q));
    cfgio_pins_model pins_u (.clk(clk), .drv_val(pin_out_q), .drv_en(pin_oe_q),
        .pull_en(pullup_en_q), .ext_val(ext_val), .ext_en(ext_en), .level(pin_in));
    // Read data stand only in the cycle after the strobe
    always @(posedge clk) rd_seen <= rd_en;
    always @(negedge clk) begin
        if (rd_seen) begin
            e_v = exp_q.size() > 0 ? exp_q.pop_front() : ~rd_data_q;
            `CHK("rd_data_q", e_v, rd_data_q)
        end
    end
    task automatic wrap_up();
        if (n_fail == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input cfgio_byte_t d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input cfgio_byte_t e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd_en <= 1'b0;
    endtask
    // Write then read with no gap, so the latch read follows its write directly
    task automatic wrrd(input logic [2:0] a, input cfgio_byte_t d, input cfgio_byte_t e);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd_en <= 1'b0;
    endtask
    // Whole-byte writes via a safe middle step, never a read-modify-write
    task automatic setcfg(input cfgio_byte_t d, input cfgio_byte_t o, input cfgio_byte_t v);
        wr(`CFGIO_OFF_OPT, 8'h00);
        wr(`CFGIO_OFF_DATA, 8'h00);
        wr(`CFGIO_OFF_DIR, 8'h00);
        wr(`CFGIO_OFF_DATA, v);
        wr(`CFGIO_OFF_OPT, o);
        wr(`CFGIO_OFF_DIR, d);
    endtask
    task automatic pin(input int g, input logic v);
        @(posedge clk);
        ext_val[g] <= v;
    endtask
    task automatic ack();
        @(posedge clk);
        irq_ack <= 1'b1;
        @(posedge clk);
        irq_ack <= 1'b0;
    endtask
    task automatic wait_irq(input logic v);
        for (int i = 0; i < 10 && irq_q !== v; i++) @(negedge clk);
        `CHK("irq_q", v, irq_q)
        if (irq_q !== v) wrap_up();
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        wrap_up();
    end
    initial begin
        void'($urandom(78540));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        `CHK("pin_oe_q", 8'h00, pin_oe_q)
        `CHK("pullup_en_q", 8'hff, pullup_en_q)
        `CHK("analog_sel_q", 8'h00, analog_sel_q)
        for (int r = 0; r < 5; r++) rd(3'(r), 8'h00);
        ext_en <= 8'hff;
        for (int i = 0; i < 6; i++) begin
            dir = 8'($urandom());
            opt = 8'($urandom());
            dat = 8'($urandom());
            an = ~dir & opt & dat;
            // Only the lowest analog candidate keeps its data bit
            dat = dat & ~(an & (an - 8'h01));
            ext_val <= 8'($urandom());
            setcfg(dir, opt, dat);
            repeat (3) @(negedge clk);
            `CHK("pin_oe_q", dir & (opt | ~dat), pin_oe_q)
            `CHK("pin_out_q", dir & opt & dat, pin_out_q)
            `CHK("pullup_en_q", ~dir & ~dat, pullup_en_q)
            an = ~dir & opt & dat & `CFGIO_ANALOG_MASK;
            `CHK("analog_sel_q", an, analog_sel_q)
            `CHK("irq_q", 1'b0, irq_q)
            // All eight pins are bonded here, so reads need no mask
            wrrd(`CFGIO_OFF_DATA, dat, (dir & dat) | (~dir & ext_val));
            rd(`CFGIO_OFF_DIR, dir);
            rd(`CFGIO_OFF_OPT, opt);
        end
        wr(3'h6, 8'hff);
        rd(3'h6, 8'h00);
        rd(`CFGIO_OFF_DIR, dir);
        ext_val <= 8'hff;
        setcfg(8'h00, 8'h04, 8'h00);
        ack();
        wr(`CFGIO_OFF_IOPT, 8'h01);
        pin(2, 1'b0);
        wait_irq(1'b1);
        @(posedge clk);
        low_power <= 1'b1;
        repeat (3) @(negedge clk);
        `CHK("wake_q", 1'b1, wake_q)
        `CHK("pullup_en_q", 8'hff, pullup_en_q)
        ack();
        low_power <= 1'b0;
        wait_irq(1'b0);
        wr(`CFGIO_OFF_IOPT, 8'h03);
        pin(2, 1'b1);
        wait_irq(1'b1);
        ack();
        wait_irq(1'b0);
        wr(`CFGIO_OFF_IOPT, 8'h05);
        pin(2, 1'b0);
        wait_irq(1'b1);
        rd(`CFGIO_OFF_STAT, 8'h02);
        pin(2, 1'b1);
        wait_irq(1'b0);
        wr(`CFGIO_OFF_IOPT, 8'h04);
        pin(2, 1'b0);
        repeat (6) @(negedge clk);
        `CHK("irq_q", 1'b0, irq_q)
        pin(2, 1'b1);
        wr(`CFGIO_OFF_IOPT, 8'h01);
        pin(5, 1'b0);
        repeat (6) @(negedge clk);
        `CHK("irq_q", 1'b0, irq_q)
        wr(`CFGIO_OFF_IOPT, 8'h07);
        pin(2, 1'b0);
        repeat (6) @(negedge clk);
        `CHK("irq_q", 1'b0, irq_q)
        rd(`CFGIO_OFF_STAT, 8'h00);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        `CHK("pullup_en_q", 8'hff, pullup_en_q)
        rd(`CFGIO_OFF_DIR, 8'h00);
        rd(`CFGIO_OFF_IOPT, 8'h00);
        repeat (2) @(negedge clk);
        wrap_up();
    end
endmodule
`default_nettype wire

// [cfgio_regs.svh]
// Register offsets, field positions and reset values of the I/O port
`ifndef CFGIO_REGS_SVH
`define CFGIO_REGS_SVH
`define CFGIO_AW 3
`define CFGIO_OFF_DATA 3'h0
`define CFGIO_OFF_DIR 3'h1
`define CFGIO_OFF_OPT 3'h2
`define CFGIO_OFF_IOPT 3'h3
`define CFGIO_OFF_STAT 3'h4
`define CFGIO_GEN_BIT 0
`define CFGIO_TRIG_LSB 1
`define CFGIO_TRIG_MSB 2
`define CFGIO_PEND_BIT 0
`define CFGIO_REQ_BIT 1
`define CFGIO_RST_BYTE 8'h00
`define CFGIO_RST_BIT 1'b0
`define CFGIO_ANALOG_MASK 8'h0f
`endif

// [cfgio_sync.sv]
// Two-flop synchroniser for the pin inputs
`timescale 1ns/1ps
`default_nettype none
module cfgio_sync
    import cfgio_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire cfgio_byte_t async_in,
    output cfgio_byte_t sync_out
);
    cfgio_byte_t meta_q;
    cfgio_byte_t sync_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= `CFGIO_RST_BYTE;
            sync_q <= `CFGIO_RST_BYTE;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule
`default_nettype wire
